// ===== include/dorc_pkg.sv
// Purpose: Shared constants for the downconverter range and preset block
// Assumes: AXI4-Lite, 32-bit data, one word per register
// Notes:   Printed offsets are register indices; byte address is index times four
package dorc_pkg;
    // Bus, sample and stretch counter widths
    localparam int AW = 12;
    localparam int SW = 16;
    localparam int CW = 11;

    // Register indices as printed
    localparam logic [AW-1:0] IDX_GAIN   = 12'h210;
    localparam logic [AW-1:0] IDX_LVL_I  = 12'h211;
    localparam logic [AW-1:0] IDX_LVL_Q  = 12'h212;
    localparam logic [AW-1:0] IDX_PIN    = 12'h213;
    localparam logic [AW-1:0] IDX_SRC    = 12'h214;
    localparam logic [AW-1:0] IDX_SEL    = 12'h215;
    localparam logic [AW-1:0] IDX_IRQST  = 12'h218;
    localparam logic [AW-1:0] IDX_IRQMSK = 12'h219;
    localparam logic [AW-1:0] IDX_CHMODE = 12'h21A;

    // Byte addresses
    localparam logic [AW-1:0] ADDR_GAIN   = IDX_GAIN << 2;
    localparam logic [AW-1:0] ADDR_LVL_I  = IDX_LVL_I << 2;
    localparam logic [AW-1:0] ADDR_LVL_Q  = IDX_LVL_Q << 2;
    localparam logic [AW-1:0] ADDR_PIN    = IDX_PIN << 2;
    localparam logic [AW-1:0] ADDR_SRC    = IDX_SRC << 2;
    localparam logic [AW-1:0] ADDR_SEL    = IDX_SEL << 2;
    localparam logic [AW-1:0] ADDR_IRQST  = IDX_IRQST << 2;
    localparam logic [AW-1:0] ADDR_IRQMSK = IDX_IRQMSK << 2;
    localparam logic [AW-1:0] ADDR_CHMODE = IDX_CHMODE << 2;

    // Reset values
    localparam logic [7:0] RST_GAIN   = 8'h00;
    localparam logic [7:0] RST_LVL_I  = 8'hF2;
    localparam logic [7:0] RST_LVL_Q  = 8'hAB;
    localparam logic [7:0] RST_PIN    = 8'h07;
    localparam logic [7:0] RST_SRC    = 8'h00;
    localparam logic [7:0] RST_SEL    = 8'h00;
    localparam logic [7:0] RST_IRQ    = 8'h00;
    localparam logic [7:0] RST_CHMODE = 8'h00;

    // Field positions
    localparam int BIT_GAIN_DOUBLE = 0;
    localparam int BIT_PIN_ENABLE  = 3;
    localparam int BIT_SINGLE_CH   = 0;

    // Shortest stretched pulse, in cycles
    localparam logic [CW-1:0] STRETCH_BASE = 11'h008;

    // Preset source modes
    localparam logic [1:0] SRC_REG   = 2'h0;
    localparam logic [1:0] SRC_PINS  = 2'h1;
    localparam logic [1:0] SRC_PIN_A = 2'h2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== include/dorc_stretch_if.sv
// Purpose: Carries one detection channel into its pulse stretcher
// Assumes: Single clock
// Notes:   One instance per range flag
`timescale 1ns/10ps
`default_nettype none
interface dorc_stretch_if;
    logic       hit;
    logic [2:0] expo;
    logic       enable;
    logic       flag;
    modport owner   (output hit, output expo, output enable, input flag);
    modport stretch (input hit, input expo, input enable, output flag);
endinterface
`default_nettype wire

// ===== hw/dorc_stretch.sv
// Purpose: Stretches one range detection into a pin pulse
// Assumes: hit is a one-cycle detection strobe
// Notes:   Pulse lasts 8 << expo cycles after the last hit
`timescale 1ns/10ps
`default_nettype none
module dorc_stretch (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Detection in, flag out
    dorc_stretch_if.stretch   sif
);
    logic [dorc_pkg::CW-1:0] cntQ;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cntQ <= '0;
        end else if (sif.hit) begin
            cntQ <= dorc_pkg::STRETCH_BASE << sif.expo;
        end else if (cntQ != '0) begin
            cntQ <= cntQ - 11'h001;
        end
    end

    // Pin gated by enable; drops when count runs out
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sif.flag <= 1'b0;
        end else begin
            sif.flag <= sif.enable & (sif.hit | (cntQ > 11'h001));
        end
    end

    a_stretch_load: assert property (@(posedge clk) disable iff (!resetn)
        sif.hit |=> cntQ == (dorc_pkg::STRETCH_BASE << $past(sif.expo)))
        else $error("stretch count not loaded");
    a_pin_gated: assert property (@(posedge clk) disable iff (!resetn)
        sif.flag |-> $past(sif.enable))
        else $error("pin high while disabled");
    a_pulse_hold: assert property (@(posedge clk) disable iff (!resetn)
        sif.hit && sif.enable ##1 sif.enable [*7] |-> sif.flag)
        else $error("pulse shorter than eight cycles");
    a_pulse_end: assert property (@(posedge clk) disable iff (!resetn)
        cntQ <= 11'h001 && !sif.hit |=> !sif.flag)
        else $error("pin stays high after hold-off");
endmodule
`default_nettype wire

// ===== hw/dorc_top.sv
// Purpose: Gain gain_double, range detection, range pins and NCO preset choice
// Assumes: Samples signed, synchronous to clk; AXI4-Lite registers
// Notes:   Only byte lane 0 of each register word is used
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module dorc_top (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // AXI4-Lite write
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Filter samples in
    input  wire logic                  sampleValid,
    input  wire logic signed [15:0]    sampleIA,
    input  wire logic signed [15:0]    sampleQA,
    input  wire logic signed [15:0]    sampleIB,
    input  wire logic signed [15:0]    sampleQB,
    // Samples out with control bits
    output logic                       outValid,
    output logic signed [15:0]         outIA,
    output logic signed [15:0]         outQA,
    output logic signed [15:0]         outIB,
    output logic signed [15:0]         outQB,
    output logic [1:0]                 ctrlBitsA,
    output logic [1:0]                 ctrlBitsB,
    // Range pins
    output logic                       range_flag_a_lo,
    output logic                       range_flag_a_hi,
    output logic                       range_flag_b_lo,
    output logic                       range_flag_b_hi,
    // Preset selection
    input  wire logic [1:0]            preset_pins_a,
    input  wire logic [1:0]            preset_pins_b,
    output logic [1:0]                 presetActA,
    output logic [1:0]                 presetActB,
    // Interrupt
    output logic                       irq
);
    logic [7:0] gainQ, lvlIQ, lvlQQ, pinQ, srcQ, selQ, irqStQ, irqMskQ, chModeQ;
    logic [11:0] awAddrQ;
    logic [7:0]  wDataQ;
    logic        awHeldQ, wHeldQ, wLaneQ, doWrite;
    logic signed [15:0] boosted [4];
    logic [15:0] mag [4];
    logic [3:0]  hits;
    logic        gainDouble, singleCh;
    logic [1:0]  nextA, nextB;

    assign gainDouble = gainQ[dorc_pkg::BIT_GAIN_DOUBLE];
    assign singleCh   = chModeQ[dorc_pkg::BIT_SINGLE_CH];

    // Saturating doubling, so a slip by software clips instead of wrapping
    function automatic logic signed [15:0] gain_double(input logic signed [15:0] s, input logic en);
        logic signed [15:0] r;
        r = s;
        if (en) begin
            if (s[15] != s[14]) begin
                r = s[15] ? 16'sh8000 : 16'sh7FFF;
            end else begin
                r = {s[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    // Gain stage per lane; magnitude against threshold
    generate
        for (genvar k = 0; k < 4; k++) begin : g_lane
            logic signed [15:0] raw;
            assign raw = (k == 0) ? sampleIA : (k == 1) ? sampleQA : (k == 2) ? sampleIB : sampleQB;
            assign boosted[k] = gain_double(raw, gainDouble);
            assign mag[k] = boosted[k][15] ? 16'(-boosted[k]) : 16'(boosted[k]);
            assign hits[k] = sampleValid & (mag[k] >= {1'b0, ((k % 2) == 0) ? lvlIQ : lvlQQ, 7'h00});
        end
    endgenerate

    // Output samples and control bits, independent of pin enable
    always_ff @(posedge clk) begin
        if (!resetn) begin
            outValid  <= 1'b0;
            outIA     <= '0;
            outQA     <= '0;
            outIB     <= '0;
            outQB     <= '0;
            ctrlBitsA <= 2'h0;
            ctrlBitsB <= 2'h0;
        end else begin
            outValid <= sampleValid;
            if (sampleValid) begin
                outIA     <= boosted[0];
                outQA     <= boosted[1];
                outIB     <= boosted[2];
                outQB     <= boosted[3];
                ctrlBitsA <= hits[1:0];
                ctrlBitsB <= hits[3:2];
            end
        end
    end

    dorc_stretch_if sIf [4] ();
    generate
        for (genvar k = 0; k < 4; k++) begin : g_str
            assign sIf[k].hit    = hits[k];
            assign sIf[k].expo   = pinQ[2:0];
            assign sIf[k].enable = pinQ[dorc_pkg::BIT_PIN_ENABLE];
            dorc_stretch u_str (
                .clk    (clk),
                .resetn (resetn),
                .sif    (sIf[k])
            );
        end
    endgenerate
    assign range_flag_a_lo = sIf[0].flag;
    assign range_flag_a_hi = sIf[1].flag;
    assign range_flag_b_lo = sIf[2].flag;
    assign range_flag_b_hi = sIf[3].flag;

    always_comb begin
        nextA = presetActA;
        nextB = presetActB;
        unique case (srcQ[1:0])
            dorc_pkg::SRC_REG: begin
                nextA = selQ[1:0];
                nextB = selQ[3:2];
            end
            dorc_pkg::SRC_PINS: begin
                nextA = preset_pins_a;
                nextB = preset_pins_b;
            end
            dorc_pkg::SRC_PIN_A: begin
                nextA = preset_pins_a;
                nextB = preset_pins_a;
            end
            default: begin
                // Reserved mode keeps the last selection
            end
        endcase
        if (singleCh) begin
            nextB = nextA;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            presetActA <= 2'h0;
            presetActB <= 2'h0;
        end else begin
            presetActA <= nextA;
            presetActB <= nextB;
        end
    end

    // Write channel: address and data taken in either order
    assign doWrite = awHeldQ & wHeldQ & ~s_axi_bvalid;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= dorc_pkg::RESP_OKAY;
            awHeldQ       <= 1'b0;
            wHeldQ        <= 1'b0;
            wLaneQ        <= 1'b0;
            awAddrQ       <= '0;
            wDataQ        <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddrQ       <= s_axi_awaddr;
                awHeldQ       <= 1'b1;
                s_axi_awready <= 1'b0;
            end else if (!awHeldQ && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wDataQ       <= s_axi_wdata[7:0];
                wLaneQ       <= s_axi_wstrb[0];
                wHeldQ       <= 1'b1;
                s_axi_wready <= 1'b0;
            end else if (!wHeldQ && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (doWrite) begin
                awHeldQ      <= 1'b0;
                wHeldQ       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddrQ inside {dorc_pkg::ADDR_GAIN, dorc_pkg::ADDR_LVL_I,
                    dorc_pkg::ADDR_LVL_Q, dorc_pkg::ADDR_PIN, dorc_pkg::ADDR_SRC, dorc_pkg::ADDR_SEL,
                    dorc_pkg::ADDR_IRQST, dorc_pkg::ADDR_IRQMSK, dorc_pkg::ADDR_CHMODE})
                    ? dorc_pkg::RESP_OKAY : dorc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration registers, reserved bits kept as written
    always_ff @(posedge clk) begin
        if (!resetn) begin
            gainQ   <= dorc_pkg::RST_GAIN;
            lvlIQ   <= dorc_pkg::RST_LVL_I;
            lvlQQ   <= dorc_pkg::RST_LVL_Q;
            pinQ    <= dorc_pkg::RST_PIN;
            srcQ    <= dorc_pkg::RST_SRC;
            selQ    <= dorc_pkg::RST_SEL;
            irqMskQ <= dorc_pkg::RST_IRQ;
            chModeQ <= dorc_pkg::RST_CHMODE;
        end else if (doWrite && wLaneQ) begin
            unique case (awAddrQ)
                dorc_pkg::ADDR_GAIN:   gainQ   <= wDataQ;
                dorc_pkg::ADDR_LVL_I:  lvlIQ   <= wDataQ;
                dorc_pkg::ADDR_LVL_Q:  lvlQQ   <= wDataQ;
                dorc_pkg::ADDR_PIN:    pinQ    <= wDataQ;
                dorc_pkg::ADDR_SRC:    srcQ    <= wDataQ;
                dorc_pkg::ADDR_SEL:    selQ    <= wDataQ;
                dorc_pkg::ADDR_IRQMSK: irqMskQ <= wDataQ;
                dorc_pkg::ADDR_CHMODE: chModeQ <= wDataQ;
                default: begin
                end
            endcase
        end
    end

    // Sticky detection status, write one to clear; a new hit beats the clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irqStQ <= dorc_pkg::RST_IRQ;
            irq    <= 1'b0;
        end else begin
            if (doWrite && wLaneQ && awAddrQ == dorc_pkg::ADDR_IRQST) begin
                irqStQ <= (irqStQ & ~wDataQ) | {4'h0, hits};
            end else begin
                irqStQ <= irqStQ | {4'h0, hits};
            end
            irq <= |(irqStQ & irqMskQ);
        end
    end

    // Read channel, one outstanding read, data registered
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= dorc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= dorc_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                dorc_pkg::ADDR_GAIN:   s_axi_rdata <= {24'h000000, gainQ};
                dorc_pkg::ADDR_LVL_I:  s_axi_rdata <= {24'h000000, lvlIQ};
                dorc_pkg::ADDR_LVL_Q:  s_axi_rdata <= {24'h000000, lvlQQ};
                dorc_pkg::ADDR_PIN:    s_axi_rdata <= {24'h000000, pinQ};
                dorc_pkg::ADDR_SRC:    s_axi_rdata <= {24'h000000, srcQ};
                dorc_pkg::ADDR_SEL:    s_axi_rdata <= {24'h000000, selQ};
                dorc_pkg::ADDR_IRQST:  s_axi_rdata <= {24'h000000, irqStQ};
                dorc_pkg::ADDR_IRQMSK: s_axi_rdata <= {24'h000000, irqMskQ};
                dorc_pkg::ADDR_CHMODE: s_axi_rdata <= {24'h000000, chModeQ};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= dorc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    a_gain_unity: assert property (@(posedge clk) disable iff (!resetn)
        sampleValid && !gainDouble |=> outIA == $past(sampleIA) && outQB == $past(sampleQB))
        else $error("unity gain path altered sample");
    a_gain_shift: assert property (@(posedge clk) disable iff (!resetn)
        sampleValid && gainDouble && sampleQA[15] == sampleQA[14] |=> outQA == 16'($past(sampleQA) <<< 1))
        else $error("gain_double did not double sample");
    a_ctrl_i_level: assert property (@(posedge clk) disable iff (!resetn)
        sampleValid |=> ctrlBitsA[0] == ($past(mag[0]) >= {1'b0, $past(lvlIQ), 7'h00}))
        else $error("I control bit wrong");
    a_ctrl_q_level: assert property (@(posedge clk) disable iff (!resetn)
        sampleValid |=> ctrlBitsB[1] == ($past(mag[3]) >= {1'b0, $past(lvlQQ), 7'h00}))
        else $error("Q control bit wrong");
    a_ctrl_no_gate: assert property (@(posedge clk) disable iff (!resetn)
        sampleValid && !pinQ[dorc_pkg::BIT_PIN_ENABLE] && hits[1] |=> ctrlBitsA[1] && !range_flag_a_hi)
        else $error("pin enable leaked into control bits");
    a_preset_reg: assert property (@(posedge clk) disable iff (!resetn)
        srcQ[1:0] == dorc_pkg::SRC_REG && !singleCh |=> presetActA == $past(selQ[1:0])
            && presetActB == $past(selQ[3:2]))
        else $error("register preset not applied");
    a_preset_pins: assert property (@(posedge clk) disable iff (!resetn)
        srcQ[1:0] == dorc_pkg::SRC_PINS && !singleCh |=> presetActB == $past(preset_pins_b))
        else $error("pins B not applied");
    a_preset_pin_a: assert property (@(posedge clk) disable iff (!resetn)
        srcQ[1:0] == dorc_pkg::SRC_PIN_A |=> presetActB == $past(preset_pins_a))
        else $error("pins A not shared");
    a_single_follow: assert property (@(posedge clk) disable iff (!resetn)
        singleCh |=> presetActB == presetActA)
        else $error("single channel not following A");
endmodule
`default_nettype wire

// ===== dv/dorc_top_tb.sv
// Purpose: Self-checking bench for the range and preset block
// Assumes: Register and sample timing as the designer handed over
// Notes:   Sample and read results are checked from queues by a monitor
`timescale 1ns/10ps
`default_nettype none
module dorc_top_tb;
    logic               clk, resetn, sv, awvalid, wvalid, bready, arvalid, rready;
    logic               awready, wready, bvalid, arready, rvalid, outValid, irq, fAL, fAH, fBL, fBH;
    logic        [11:0] awaddr, araddr;
    logic        [31:0] wdata, rdata;
    logic         [1:0] bresp, rresp, ctA, ctB, pa, pb, actA, actB, eA, eB, paV, pbV;
    logic signed [15:0] iA, qA, iB, qB, oIA, oQA, oIB, oQB;
    logic         [7:0] thI, thQ, sel;
    logic         [3:0] strb;
    logic               gainOn;
    logic        [67:0] sq[$];
    logic        [33:0] rq[$];
    int                 err_total = 0;
    int                 cmp_count = 0;
    int                 g, k, m, s, cnt;
    logic        [11:0] ra[9] = '{dorc_pkg::ADDR_GAIN, dorc_pkg::ADDR_LVL_I, dorc_pkg::ADDR_LVL_Q,
        dorc_pkg::ADDR_PIN, dorc_pkg::ADDR_SRC, dorc_pkg::ADDR_SEL, dorc_pkg::ADDR_IRQST,
        dorc_pkg::ADDR_IRQMSK, dorc_pkg::ADDR_CHMODE};
    logic         [7:0] rv[9] = '{8'h00, 8'hF2, 8'hAB, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    dorc_top dorc_top_inst (
        .clk(clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sampleValid(sv), .sampleIA(iA), .sampleQA(qA), .sampleIB(iB),
        .sampleQB(qB), .outValid(outValid), .outIA(oIA), .outQA(oQA), .outIB(oIB), .outQB(oQB),
        .ctrlBitsA(ctA), .ctrlBitsB(ctB), .range_flag_a_lo(fAL), .range_flag_a_hi(fAH),
        .range_flag_b_lo(fBL), .range_flag_b_hi(fBH), .preset_pins_a(pa), .preset_pins_b(pb),
        .presetActA(actA), .presetActB(actB), .irq(irq)
    );

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string nm, input logic [67:0] e, input logic [67:0] v);
        cmp_count++;
        if (v !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, v);
        end
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #40000;
        err_total++;
        print_verdict;
    end

    // Oldest note against each result that appears
    always @(posedge clk) begin
        if (rvalid && rready) check("read", {34'h0, rq.pop_front()}, {34'h0, rresp, rdata});
        if (outValid) check("sample", sq.pop_front(), {oIA, oQA, oIB, oQB, ctA, ctB});
    end

    // Boosted, saturated value with threshold hit on top
    function automatic logic [16:0] sx(input logic signed [15:0] x, input logic [7:0] t);
        logic signed [16:0] y;
        logic        [16:0] mg;
        y = gainOn ? {x, 1'b0} : {x[15], x};
        if (y > 17'sh07FFF) y = 17'sh07FFF;
        if (y < -17'sh08000) y = -17'sh08000;
        mg = (y < 0) ? -y : y;
        // Full scale is 2^15, so one threshold step is 128 counts
        return {mg >= {2'b00, t, 7'h00}, y[15:0]};
    endfunction

    // Leaves valid high so samples can run back to back
    task automatic smp(input logic signed [15:0] a, b, c, d);
        logic [16:0] ea, eb, ec, ed;
        ea = sx(a, thI);
        eb = sx(b, thQ);
        ec = sx(c, thI);
        ed = sx(d, thQ);
        sq.push_back({ea[15:0], eb[15:0], ec[15:0], ed[15:0], eb[16], ea[16], ed[16], ec[16]});
        iA <= a;
        qA <= b;
        iB <= c;
        qB <= d;
        sv <= 1'b1;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        check("bresp", 68'(er), 68'(bresp));
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        rq.push_back({er, 24'h0, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // Write, then the interrupt level that must follow
    task automatic wi(input logic [11:0] a, input logic [7:0] d, input logic e);
        wr(a, d, dorc_pkg::RESP_OKAY);
        check("irq", 68'(e), 68'(irq));
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, sv} = '0;
        {awaddr, araddr, wdata, iA, qA, iB, qB, pa, pb} = '0;
        {gainOn, thI, thQ, resetn} = {1'b0, 8'hF2, 8'hAB, 1'b0};
        strb = 4'hF;
        void'($urandom(32'h7983));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // Reset values, unmapped place, read back
        foreach (ra[i]) rd(ra[i], rv[i], dorc_pkg::RESP_OKAY);
        rd(12'h870, 8'h00, dorc_pkg::RESP_SLVERR);
        wr(12'h870, 8'hFF, dorc_pkg::RESP_SLVERR);
        // Lane 0 strobe low leaves the register untouched
        strb <= 4'hE;
        wr(dorc_pkg::ADDR_LVL_Q, 8'h55, dorc_pkg::RESP_OKAY);
        strb <= 4'hF;
        rd(dorc_pkg::ADDR_LVL_Q, dorc_pkg::RST_LVL_Q, dorc_pkg::RESP_OKAY);
        sel = 8'($urandom);
        wr(dorc_pkg::ADDR_LVL_Q, sel, dorc_pkg::RESP_OKAY);
        rd(dorc_pkg::ADDR_LVL_Q, sel, dorc_pkg::RESP_OKAY);
        {thI, thQ} = 16'h2040;
        wr(dorc_pkg::ADDR_LVL_I, thI, dorc_pkg::RESP_OKAY);
        wr(dorc_pkg::ADDR_LVL_Q, thQ, dorc_pkg::RESP_OKAY);
        for (g = 0; g < 2; g++) begin
            gainOn = g[0];
            wr(dorc_pkg::ADDR_GAIN, {7'h0, gainOn}, dorc_pkg::RESP_OKAY);
            smp(16'h1000, 16'h1FFF, 16'h8000, 16'h7FFF);
            smp(-16'sh1000, 16'h2000, 16'h0FFF, 16'h0800);
            repeat (30) smp(16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom));
            sv <= 1'b0;
            repeat (2) @(posedge clk);
        end
        // pins held low while bits still tagged
        wr(dorc_pkg::ADDR_PIN, 8'h00, dorc_pkg::RESP_OKAY);
        smp(16'h7000, 16'h7000, 16'h7000, 16'h7000);
        sv <= 1'b0;
        repeat (12) begin
            @(posedge clk);
            check("pins", 68'h0, 68'({fAL, fAH, fBL, fBH}));
        end
        for (g = 0; g < 3; g += 2) begin
            wr(dorc_pkg::ADDR_PIN, 8'h08 | 8'(g), dorc_pkg::RESP_OKAY);
            smp(16'h7000, 16'h7000, 16'h7000, 16'h7000);
            sv <= 1'b0;
            cnt = 0;
            repeat ((8 << g) + 4) begin
                @(posedge clk);
                cnt += (fAL & fAH & fBL & fBH);
            end
            check("stretch", 68'(8 << g), 68'(cnt));
        end
        // Sticky status, mask, write one to clear
        wr(dorc_pkg::ADDR_IRQST, 8'h0F, dorc_pkg::RESP_OKAY);
        rd(dorc_pkg::ADDR_IRQST, 8'h00, dorc_pkg::RESP_OKAY);
        smp(16'h7000, 16'h0000, 16'h0000, 16'h0000);
        sv <= 1'b0;
        rd(dorc_pkg::ADDR_IRQST, 8'h01, dorc_pkg::RESP_OKAY);
        wi(dorc_pkg::ADDR_IRQMSK, 8'h01, 1'b1);
        wi(dorc_pkg::ADDR_IRQMSK, 8'h0E, 1'b0);
        wi(dorc_pkg::ADDR_IRQMSK, 8'h01, 1'b1);
        wi(dorc_pkg::ADDR_IRQST, 8'h01, 1'b0);
        rd(dorc_pkg::ADDR_IRQST, 8'h00, dorc_pkg::RESP_OKAY);
        for (m = 0; m < 4; m++) begin
            for (s = 0; s < 2; s++) begin
                {sel, paV, pbV} = 12'($urandom);
                wr(dorc_pkg::ADDR_SRC, 8'(m), dorc_pkg::RESP_OKAY);
                wr(dorc_pkg::ADDR_CHMODE, 8'(s), dorc_pkg::RESP_OKAY);
                wr(dorc_pkg::ADDR_SEL, sel, dorc_pkg::RESP_OKAY);
                pa <= paV;
                pb <= pbV;
                repeat (3) @(posedge clk);
                if (m == 0) {eA, eB} = {sel[1:0], (s != 0) ? sel[1:0] : sel[3:2]};
                else if (m != 3) {eA, eB} = {paV, (m == 2 || s != 0) ? paV : pbV};
                check("preset", 68'({eA, eB}), 68'({actA, actB}));
            end
        end
        // Mid-run reset brings registers and presets back
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(dorc_pkg::ADDR_PIN, dorc_pkg::RST_PIN, dorc_pkg::RESP_OKAY);
        rd(dorc_pkg::ADDR_SEL, dorc_pkg::RST_SEL, dorc_pkg::RESP_OKAY);
        check("preset", 68'h0, 68'({actA, actB}));
        print_verdict;
    end
endmodule
`default_nettype wire
